/* inc/uilc_pkg.sv */
// package for the uart interrupt, fifo control and line format block
// assumes a single 100 MHz clock domain and an axi4-lite master
package uilc_pkg;
	localparam logic [7:0] UILC_ISR_OFS = 8'h00;
	localparam logic [7:0] UILC_FCR_OFS = 8'h04;
	localparam logic [7:0] UILC_LCR_OFS = 8'h08;
	localparam logic [7:0] UILC_CTL_OFS = 8'h0C;
	localparam logic [7:0] UILC_STS_OFS = 8'h10;
	localparam logic [7:0] UILC_LCR_RST = 8'h00;
	localparam logic [7:0] UILC_FCR_RST = 8'h00;
	localparam logic [7:0] UILC_ISR_NONE = 8'h01;
	localparam logic [1:0] UILC_RESP_OKAY = 2'h0;
	localparam logic [1:0] UILC_RESP_SLVERR = 2'h2;
	localparam int UILC_FCR_EN = 0;
	localparam int UILC_FCR_RXRST = 1;
	localparam int UILC_FCR_TXRST = 2;
	localparam int UILC_FCR_BLK = 3;
	localparam int UILC_EFR_EN = 4;
	localparam int UILC_LCR_BRK = 6;

	typedef struct packed {
		logic line_status;
		logic rx_ready;
		logic rx_timeout;
		logic tx_empty;
		logic modem;
	} uilc_src_t;

	typedef struct packed {
		logic [6:0] rx_level;
		logic [6:0] tx_level;
	} uilc_trig_t;

	typedef struct packed {
		logic [3:0] data_bits;
		logic [1:0] stop_half_bits;
		logic parity_en;
		logic parity_force;
		logic parity_value;
		logic even;
	} uilc_fmt_t;
endpackage

/* verilog/uilc_ctrl.sv */
// interrupt status, fifo control and line format registers of one uart channel
// assumes fifo, receiver and transmitter sit outside and use the derived controls
// Overview of operation
// [R1] status bit 0 reads 0 when anything pending, 1 when idle
// [R2] status bits 3:1 encode line, rx ready, rx timeout, tx empty
// [R3] only highest pending source reported; line status highest, pin change lowest
// [R4] status bit 4 set on flow or special char match, enhanced mode only
// [R5] flow char flag cleared by status read; last flow char kept separately
// [R6] special char flag cleared by status read or next received char
// [R7] status bit 5 set on cts or rts rising, enhanced mode only
// [R8] status bits 7:6 read 1 with fifos enabled, else 0
// [R9] fifo bit 0 enables fifos; other bits ignored when it is 0
// [R10] rx fifo reset bit pulses rx pointer clear, self-clears
// [R11] tx fifo reset bit pulses tx pointer clear, self-clears
// [R12] block-transfer mode bit is stored but does nothing
// [R13] tx request when level below trigger, or empty after short reload
// [R14] tx trigger select writable only with enhanced enable set
// [R15] one trigger table serves both directions
// [R16] table select 00..11 chooses tables a, b, c, d
// [R17] table a: rx 1,4,8,14; tx 1
// [R18] table b: rx 8,16,24,28; tx 16,8,24,30
// [R19] table c: rx 8,16,56,60; tx 8,16,32,56
// [R20] format bits 1:0 give 5 to 8 data bits
// [R21] stop bit: 1, or 1.5 for 5 bits, 2 otherwise
// [R22] format bit 3 enables parity generation and checking
// [R23] format bit 4 selects odd (0) or even (1)
// [R24] format bit 5 forces parity to inverse of bit 4
// [R25] format bit 6 holds serial output low until cleared
// [R26] table d uses externally programmed trigger levels
module uilc_ctrl
	import uilc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire uilc_src_t src_pending,
	input wire logic [1:0] trigger_table_select_reg,
	input wire uilc_trig_t prog_trig,
	input wire logic flow_char_match,
	input wire logic flow_char_is_xoff,
	input wire logic special_char_match,
	input wire logic rx_char_done,
	input wire logic [6:0] tx_fifo_count,
	input wire logic tx_reload_done,
	input wire logic cts_pin,
	input wire logic rts_out,
	input wire logic tx_serial_in,
	output logic tx_serial,
	output logic rx_fifo_clear,
	output logic tx_fifo_clear,
	output logic fifo_enable,
	output logic tx_request,
	output uilc_trig_t trig_level,
	output uilc_fmt_t line_fmt
);
	logic [7:0] fifo_setup_control;
	logic [7:0] serial_line_format;
	logic enhanced_feature_enable_reg;
	logic last_flow_char_indicator;
	logic flow_flag, special_flag, pin_flag;
	logic cts_s1, cts_s2, cts_d;
	logic [6:0] next_rx_trig, next_tx_trig;
	logic tx_below, reload_short;
	logic [7:0] isr_value;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic aw_held, w_held;
	logic do_write, isr_read;
	logic rts_d;

	function automatic logic [6:0] uilc_pick(input logic [1:0] sel, input logic [27:0] tab);
		uilc_pick = tab[7*sel +: 7];
	endfunction

	// write channel capture, either order
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wa <= 8'h00;
			wd <= 32'h0000_0000;
			ws <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= UILC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wa <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa[7:2] <= UILC_CTL_OFS[7:2] && wa[7:2] != UILC_ISR_OFS[7:2])
					? UILC_RESP_OKAY : UILC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// fifo setup register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fifo_setup_control <= UILC_FCR_RST;
			rx_fifo_clear <= 1'b0;
			tx_fifo_clear <= 1'b0;
		end else begin
			rx_fifo_clear <= 1'b0;
			tx_fifo_clear <= 1'b0;
			if (do_write && wa[7:2] == UILC_FCR_OFS[7:2] && ws[0]) begin
				fifo_setup_control[UILC_FCR_EN] <= wd[UILC_FCR_EN]; // [R9]
				if (wd[UILC_FCR_EN]) begin
					rx_fifo_clear <= wd[UILC_FCR_RXRST]; // [R10]
					tx_fifo_clear <= wd[UILC_FCR_TXRST]; // [R11]
					fifo_setup_control[UILC_FCR_BLK] <= wd[UILC_FCR_BLK]; // [R12]
					fifo_setup_control[7:6] <= wd[7:6];
					if (enhanced_feature_enable_reg)
						fifo_setup_control[5:4] <= wd[5:4]; // [R14]
				end
			end
			// reset bits never stored: they read back as zero
			fifo_setup_control[2:1] <= 2'b00;
		end
	end

	// line format and enhanced enable
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			serial_line_format <= UILC_LCR_RST;
			enhanced_feature_enable_reg <= 1'b0;
		end else if (do_write && ws[0]) begin
			if (wa[7:2] == UILC_LCR_OFS[7:2])
				serial_line_format <= wd[7:0];
			if (wa[7:2] == UILC_CTL_OFS[7:2])
				enhanced_feature_enable_reg <= wd[UILC_EFR_EN];
		end
	end

	// pin change detect; cts is asynchronous
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cts_s1 <= 1'b0;
			cts_s2 <= 1'b0;
			cts_d <= 1'b0;
			rts_d <= 1'b0;
		end else begin
			cts_s1 <= cts_pin;
			cts_s2 <= cts_s1;
			cts_d <= cts_s2;
			rts_d <= rts_out;
		end
	end

	assign isr_read = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == UILC_ISR_OFS[7:2];

	// sticky flags; a new event beats the read clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flow_flag <= 1'b0;
			special_flag <= 1'b0;
			pin_flag <= 1'b0;
			last_flow_char_indicator <= 1'b0;
		end else begin
			if (enhanced_feature_enable_reg && flow_char_match) begin
				flow_flag <= 1'b1; // [R4]
				last_flow_char_indicator <= flow_char_is_xoff; // [R5]
			end else if (isr_read) begin
				flow_flag <= 1'b0; // [R5]
			end
			if (enhanced_feature_enable_reg && special_char_match)
				special_flag <= 1'b1; // [R4]
			else if (isr_read || rx_char_done)
				special_flag <= 1'b0; // [R6]
			if (enhanced_feature_enable_reg && ((cts_s2 && !cts_d) || (rts_out && !rts_d)))
				pin_flag <= 1'b1; // [R7]
			else if (isr_read)
				pin_flag <= 1'b0;
		end
	end

	// priority encode, one source shown at a time
	always_comb begin
		isr_value = UILC_ISR_NONE;
		if (src_pending.line_status) // [R3]
			isr_value = 8'h06; // [R2]
		else if (src_pending.rx_ready)
			isr_value = 8'h04; // [R2]
		else if (src_pending.rx_timeout)
			isr_value = 8'h0C; // [R2]
		else if (src_pending.tx_empty || tx_request)
			isr_value = 8'h02; // [R2]
		else if (src_pending.modem)
			isr_value = 8'h00; // [R1]
		else if (flow_flag || special_flag)
			isr_value = 8'h10; // [R4]
		else if (pin_flag)
			isr_value = 8'h20; // [R7]
		isr_value[7:6] = {2{fifo_setup_control[UILC_FCR_EN]}}; // [R8]
	end

	// read channel
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= UILC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= UILC_RESP_OKAY;
				unique case (s_axi_araddr[7:2])
					UILC_ISR_OFS[7:2]: s_axi_rdata <= {24'h00_0000, isr_value};
					UILC_FCR_OFS[7:2]: s_axi_rdata <= 32'h0000_0000;
					UILC_LCR_OFS[7:2]: s_axi_rdata <= {24'h00_0000, serial_line_format};
					UILC_CTL_OFS[7:2]: s_axi_rdata <= {27'h000_0000, enhanced_feature_enable_reg, 4'h0};
					UILC_STS_OFS[7:2]: s_axi_rdata <= {31'h0000_0000, last_flow_char_indicator};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= UILC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// trigger tables, one selection for both directions
	always_comb begin
		unique case (trigger_table_select_reg) // [R15] [R16]
			2'b00: begin
				next_rx_trig = uilc_pick(fifo_setup_control[7:6], {7'd14, 7'd8, 7'd4, 7'd1}); // [R17]
				next_tx_trig = 7'd1; // [R17]
			end
			2'b01: begin
				next_rx_trig = uilc_pick(fifo_setup_control[7:6], {7'd28, 7'd24, 7'd16, 7'd8}); // [R18]
				next_tx_trig = uilc_pick(fifo_setup_control[5:4], {7'd30, 7'd24, 7'd8, 7'd16}); // [R18]
			end
			2'b10: begin
				next_rx_trig = uilc_pick(fifo_setup_control[7:6], {7'd60, 7'd56, 7'd16, 7'd8}); // [R19]
				next_tx_trig = uilc_pick(fifo_setup_control[5:4], {7'd56, 7'd32, 7'd16, 7'd8}); // [R19]
			end
			2'b11: begin
				next_rx_trig = prog_trig.rx_level; // [R26]
				next_tx_trig = prog_trig.tx_level; // [R26]
			end
		endcase
	end

	// tx request: below trigger, or empty when last reload stayed short
	assign tx_below = tx_fifo_count < trig_level.tx_level;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reload_short <= 1'b0;
			tx_request <= 1'b0;
			trig_level <= '0;
			fifo_enable <= 1'b0;
		end else begin
			trig_level.rx_level <= next_rx_trig;
			trig_level.tx_level <= next_tx_trig;
			fifo_enable <= fifo_setup_control[UILC_FCR_EN];
			if (tx_reload_done)
				reload_short <= tx_fifo_count <= trig_level.tx_level;
			// crossing below does not count if the last reload left fifo at or under trigger
			tx_request <= fifo_setup_control[UILC_FCR_EN]
				&& ((tx_below && !reload_short) || tx_fifo_count == 7'd0); // [R13]
		end
	end

	// line format decode for transmitter and receiver
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			line_fmt <= '0;
			tx_serial <= 1'b1;
		end else begin
			line_fmt.data_bits <= 4'd5 + {2'b00, serial_line_format[1:0]}; // [R20]
			line_fmt.stop_half_bits <= !serial_line_format[2] ? 2'd2 :
				(serial_line_format[1:0] == 2'b00 ? 2'd3 : 2'd0); // [R21]
			line_fmt.parity_en <= serial_line_format[3]; // [R22]
			line_fmt.even <= serial_line_format[4]; // [R23]
			line_fmt.parity_force <= serial_line_format[5]; // [R24]
			line_fmt.parity_value <= !serial_line_format[4]; // [R24]
			tx_serial <= serial_line_format[UILC_LCR_BRK] ? 1'b0 : tx_serial_in; // [R25]
		end
	end
endmodule

/* dv/uilc_ctrl_props.sv */
// checker for the uart control block
// assumes it is bound to uilc_ctrl and sees only its ports
module uilc_ctrl_props
	import uilc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] trigger_table_select_reg,
	input wire uilc_trig_t prog_trig,
	input wire logic tx_serial_in,
	input wire logic tx_serial,
	input wire logic rx_fifo_clear,
	input wire logic tx_fifo_clear,
	input wire logic fifo_enable,
	input wire uilc_trig_t trig_level,
	input wire uilc_fmt_t line_fmt
);
	logic rd_stat;
	// one read at a time, so the flag stays valid until rvalid
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			rd_stat <= 1'b0;
		else if (s_axi_arready)
			rd_stat <= (s_axi_araddr == UILC_ISR_OFS);
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	line_low_a: assert property (!tx_serial_in |=> !tx_serial) else $error("tx line not low");
	rx_clr_pulse_a: assert property (rx_fifo_clear |=> !rx_fifo_clear) else $error("rx clear long");
	tx_clr_pulse_a: assert property (tx_fifo_clear |=> !tx_fifo_clear) else $error("tx clear long");
	// fifo_enable is a register of the setup bit, so it shows the enabling write one cycle after the pulse
	clr_needs_en_a: assert property ((rx_fifo_clear || tx_fifo_clear) |=> fifo_enable) else $error("clear off");
	table_a_tx_a: assert property (trigger_table_select_reg == 2'h0 |=> trig_level.tx_level == 7'h01)
		else $error("table a tx level");
	table_d_a: assert property (trigger_table_select_reg == 2'h3 |=> trig_level == $past(prog_trig))
		else $error("table d level");
	fmt_len_a: assert property ($past(resetn) |-> line_fmt.data_bits >= 4'h5 && line_fmt.data_bits <= 4'h8)
		else $error("data bits range");
	fmt_stop_a: assert property ($past(resetn) |-> (line_fmt.data_bits == 4'h5 ? line_fmt.stop_half_bits != 2'h0
		: line_fmt.stop_half_bits != 2'h3) && line_fmt.stop_half_bits != 2'h1) else $error("stop length");
	fifo_bits_a: assert property (s_axi_rvalid && rd_stat |-> s_axi_rdata[7:6] == {2{fifo_enable}})
		else $error("status fifo bits");
	cover property (rx_fifo_clear);
	cover property (s_axi_rvalid && rd_stat);
	cover property (!tx_serial && tx_serial_in);
endmodule

bind uilc_ctrl uilc_ctrl_props props_u (.clock(clock), .resetn(resetn), .s_axi_araddr(s_axi_araddr),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
	.trigger_table_select_reg(trigger_table_select_reg), .prog_trig(prog_trig), .tx_serial_in(tx_serial_in),
	.tx_serial(tx_serial), .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear),
	.fifo_enable(fifo_enable), .trig_level(trig_level), .line_fmt(line_fmt));

/* dv/uilc_remote.sv */
// remote serial party: watches the line, drives its clear-to-send pin
// assumes the pin is unrelated in phase to the local clock
module uilc_remote (
	input wire logic clock,
	input wire logic tx_line,
	input wire logic cts_req,
	output logic cts_pin,
	output int low_run
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cts_pin = 1'b0;
	initial low_run = 0;
	// off-grid edge so the sync stage is exercised
	always @(cts_req) cts_pin <= #3 cts_req;
	// a break shows as a long unbroken space
	always @(posedge clock) low_run <= tx_line ? 0 : low_run + 1;
endmodule

/* dv/uilc_ctrl_tb.sv */
// self-checking bench for the uart control block
// assumes the block alone, a remote line model and a bus master task set
module uilc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import uilc_pkg::*;
	logic clock = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, flow_char_match = 0, flow_char_is_xoff = 0, special_char_match = 0, rx_char_done = 0;
	logic tx_reload_done = 0, cts_req = 0, cts_pin, rts_out = 0, tx_serial_in = 1;
	logic tx_serial, rx_fifo_clear, tx_fifo_clear, fifo_enable, tx_request;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, trigger_table_select_reg = 0;
	logic [6:0] tx_fifo_count = 0;
	uilc_src_t src_pending = 0;
	uilc_trig_t prog_trig = 0, trig_level;
	uilc_fmt_t line_fmt;
	int bad_count = 0, samples_checked = 0, rx_n = 0, tx_n = 0, low_run;
	int rxl[12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};
	int txl[12] = '{1, 1, 1, 1, 16, 8, 24, 30, 8, 16, 32, 56};
	logic [7:0] enc[6] = '{8'h06, 8'h04, 8'h0c, 8'h02, 8'h00, 8'h01};
	always #5 clock = ~clock;
	always @(posedge clock) begin
		rx_n += rx_fifo_clear;
		tx_n += tx_fifo_clear;
	end
	uilc_ctrl dut_u (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_pending,
		.trigger_table_select_reg, .prog_trig, .flow_char_match, .flow_char_is_xoff, .special_char_match,
		.rx_char_done, .tx_fifo_count, .tx_reload_done, .cts_pin, .rts_out, .tx_serial_in, .tx_serial,
		.rx_fifo_clear, .tx_fifo_clear, .fifo_enable, .tx_request, .trig_level, .line_fmt);
	uilc_remote remote_u (.clock, .tx_line(tx_serial), .cts_req, .cts_pin, .low_run);
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task t_reset;
		rd(UILC_ISR_OFS);
		chk("status", UILC_ISR_NONE, rd_v);
		rd(UILC_LCR_OFS);
		chk("format", UILC_LCR_RST, rd_v);
		chk("reset bits", 5, line_fmt.data_bits);
		chk("reset stop", 2, line_fmt.stop_half_bits);
		rd(8'h20);
		chk("unmapped rresp", UILC_RESP_SLVERR, rsp);
		wr(UILC_ISR_OFS, 8'h00);
		chk("status bresp", UILC_RESP_SLVERR, rsp);
	endtask
	task t_prio;
		for (int i = 0; i < 6; i++) begin
			@(posedge clock) src_pending <= 5'h1f >> i;
			rd(UILC_ISR_OFS);
			chk("priority", enc[i], rd_v);
		end
	endtask
	task t_fifo;
		wr(UILC_FCR_OFS, 8'h06);
		repeat (3) @(posedge clock);
		chk("fifo off", 0, fifo_enable + rx_n + tx_n);
		wr(UILC_FCR_OFS, 8'h0f);
		repeat (3) @(posedge clock);
		chk("fifo on", 1, fifo_enable);
		chk("rx clears", 1, rx_n);
		chk("tx clears", 1, tx_n);
		rd(UILC_FCR_OFS);
		chk("fifo rd", 0, rd_v);
		// tx fifo still empty: the tx request shows at priority 4
		rd(UILC_ISR_OFS);
		chk("status tx empty", 8'hc2, rd_v);
		@(posedge clock) tx_fifo_count <= 7'h10;
		repeat (2) @(posedge clock);
		rd(UILC_ISR_OFS);
		chk("status on", 8'hc1, rd_v);
	endtask
	task t_trig;
		@(posedge clock) trigger_table_select_reg <= 2'h1;
		wr(UILC_FCR_OFS, 8'hf1);
		repeat (2) @(posedge clock);
		chk("rx level", 28, trig_level.rx_level);
		chk("tx locked", 16, trig_level.tx_level);
		wr(UILC_CTL_OFS, 8'h10);
		for (int t = 0; t < 3; t++) begin
			for (int s = 0; s < 4; s++) begin
				@(posedge clock) trigger_table_select_reg <= 2'(t);
				wr(UILC_FCR_OFS, 32'(8'h01 | (s << 6) | (s << 4)));
				repeat (2) @(posedge clock);
				chk("rx level", rxl[t * 4 + s], trig_level.rx_level);
				chk("tx level", txl[t * 4 + s], trig_level.tx_level);
			end
		end
		@(posedge clock) trigger_table_select_reg <= 2'h3;
		prog_trig <= {7'h28, 7'h14};
		tx_fifo_count <= 7'h05;
		repeat (3) @(posedge clock);
		chk("table d", {7'h28, 7'h14}, trig_level);
		chk("tx below", 1, tx_request);
		tx_fifo_count <= 7'h1e;
		repeat (3) @(posedge clock);
		chk("tx above", 0, tx_request);
		// a reload that stays at or under the trigger only requests once empty
		tx_fifo_count <= 7'h05;
		tx_reload_done <= 1;
		@(posedge clock) tx_reload_done <= 0;
		repeat (3) @(posedge clock);
		chk("short reload", 0, tx_request);
		tx_fifo_count <= 7'h00;
		repeat (3) @(posedge clock);
		chk("empty after short", 1, tx_request);
		tx_fifo_count <= 7'h1e;
		repeat (3) @(posedge clock);
		chk("refilled", 0, tx_request);
	endtask
	task t_fmt;
		for (int v = 0; v < 64; v++) begin
			wr(UILC_LCR_OFS, v);
			rd(UILC_LCR_OFS);
			chk("format rb", v, rd_v);
			chk("bits", 5 + v % 4, line_fmt.data_bits);
			chk("stop", !v[2] ? 2 : (v % 4 == 0 ? 3 : 0), line_fmt.stop_half_bits);
			chk("parity", v[3], line_fmt.parity_en);
			chk("force", v[5], line_fmt.parity_force);
			if (v[5]) chk("forced", !v[4], line_fmt.parity_value);
			else chk("even", v[4], line_fmt.even);
		end
	endtask
	task t_break;
		wr(UILC_LCR_OFS, 8'h43);
		// the remote counts on its own edge, one behind what it has seen
		repeat (21) @(posedge clock);
		chk("break", 1, low_run >= 20);
		wr(UILC_LCR_OFS, 8'h03);
		repeat (3) @(posedge clock);
		chk("idle", 1, tx_serial);
		tx_serial_in <= 0;
		repeat (2) @(posedge clock);
		chk("follow low", 0, tx_serial);
		tx_serial_in <= 1;
		repeat (2) @(posedge clock);
		chk("follow high", 1, tx_serial);
	endtask
	task t_flags;
		@(posedge clock) flow_char_match <= 1;
		flow_char_is_xoff <= 1;
		@(posedge clock) flow_char_match <= 0;
		rd(UILC_ISR_OFS);
		chk("flow", 8'hd0, rd_v);
		rd(UILC_ISR_OFS);
		chk("flow read", 8'hc1, rd_v);
		rd(UILC_STS_OFS);
		chk("last char", 1, rd_v);
		@(posedge clock) flow_char_match <= 1;
		flow_char_is_xoff <= 0;
		@(posedge clock) flow_char_match <= 0;
		rd(UILC_STS_OFS);
		chk("last char xon", 0, rd_v);
		rd(UILC_ISR_OFS);
		chk("flow again", 8'hd0, rd_v);
		@(posedge clock) special_char_match <= 1;
		@(posedge clock) special_char_match <= 0;
		rd(UILC_ISR_OFS);
		chk("special", 8'hd0, rd_v);
		rd(UILC_ISR_OFS);
		chk("special read", 8'hc1, rd_v);
		@(posedge clock) special_char_match <= 1;
		@(posedge clock) special_char_match <= 0;
		rx_char_done <= 1;
		@(posedge clock) rx_char_done <= 0;
		rd(UILC_ISR_OFS);
		chk("special next", 8'hc1, rd_v);
		@(posedge clock) cts_req <= 1;
		repeat (6) @(posedge clock);
		rd(UILC_ISR_OFS);
		chk("pin", 8'he0, rd_v);
		@(posedge clock) rts_out <= 1;
		repeat (2) @(posedge clock);
		rd(UILC_ISR_OFS);
		chk("rts", 8'he0, rd_v);
		rd(UILC_ISR_OFS);
		chk("pin read", 8'hc1, rd_v);
		wr(UILC_CTL_OFS, 8'h00);
		@(posedge clock) special_char_match <= 1;
		rts_out <= 0;
		@(posedge clock) special_char_match <= 0;
		rts_out <= 1;
		repeat (2) @(posedge clock);
		rd(UILC_ISR_OFS);
		chk("plain", 8'hc1, rd_v);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1;
		t_reset;
		t_prio;
		t_fifo;
		t_trig;
		t_fmt;
		t_break;
		t_flags;
		close_out;
	end
	// generous: the whole run is about a thousand cycles
	initial begin
		#200000;
		bad_count++;
		close_out;
	end
endmodule
